// [logic/wwrf_pkg.sv]
// shared constants of the watchdog with reset-cause flags
package wwrf_pkg;
  // register byte addresses
  localparam logic [31:0] WWRF_CTL_ADDR = 32'h0000_0000;
  localparam logic [31:0] WWRF_STS_ADDR = 32'h0000_0004;
  // watchdog_control fields
  localparam int unsigned CTL_IRQ_FLAG = 7;
  localparam int unsigned CTL_IRQ_EN   = 6;
  localparam int unsigned CTL_PER_HI   = 5;
  localparam int unsigned CTL_UNLOCK   = 4;
  localparam int unsigned CTL_RST_EN   = 3;
  localparam int unsigned CTL_PER_LO   = 0;
  // reset_cause_status fields
  localparam int unsigned STS_WDOG = 3;
  localparam int unsigned STS_BOR  = 2;
  localparam int unsigned STS_PIN  = 1;
  localparam int unsigned STS_POR  = 0;
  // values after power-on
  localparam logic [3:0] STS_RESET    = 4'h1;
  localparam logic [3:0] PERIOD_RESET = 4'h0;
  // timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned OSC_HZ        = 128_000;
  localparam int unsigned OSC_DIV       = CLK_HZ / OSC_HZ;
  localparam int unsigned TIMEOUT_BASE  = 2048;
  localparam logic [3:0]  PERIOD_MAX    = 4'h9;
  localparam logic [2:0]  UNLOCK_CYCLES = 3'h4;
  localparam int unsigned CNT_W         = 21;
endpackage

// [logic/wwrf_sync.sv]
// two-flop synchroniser for asynchronous level inputs
module wwrf_sync
  import wwrf_pkg::*;
#(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] hold;
  } wwrf_sync_t;

  wwrf_sync_t s;
  wwrf_sync_t next_s;

  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.meta = d;
      next_s.hold = s.meta;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= {RST, RST};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.hold;
endmodule

// [logic/wwrf_tick.sv]
// divider that stands in for the separate watchdog oscillator
module wwrf_tick
  import wwrf_pkg::*;
#(
  parameter int unsigned DIV = OSC_DIV
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  output logic      tick
);
  localparam int unsigned DW = $clog2(DIV + 1);
  localparam logic [DW-1:0] LAST = DW'(DIV - 1);

  typedef struct packed {
    logic [DW-1:0] cnt;
    logic          tick;
  } wwrf_tick_t;

  wwrf_tick_t s;
  wwrf_tick_t next_s;

  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.tick = (s.cnt == LAST);
      next_s.cnt  = (s.cnt == LAST) ? '0 : s.cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

// [logic/wwrf_top.sv]
// watchdog timer with reset-cause flags, AHB-Lite register slave
//
// The address map and the AHB-Lite slave port were left to the implementer.
module wwrf_top
  import wwrf_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_BASE,
  parameter int unsigned TICK_DIV       = OSC_DIV
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        wdog_restart,
  input  wire logic        irq_vector_taken,
  input  wire logic        global_irq_enable,
  input  wire logic        brownout_detect,
  input  wire logic        reset_pin_n,
  input  wire logic        always_on_fuse,
  output logic             irq_request,
  output logic             sys_reset_pulse
);
  typedef struct packed {
    logic             wr_ctl;
    logic             wr_sts;
    logic [31:0]      rdata;
    logic             irq_flag;
    logic             irq_en;
    logic             unlock;
    logic [2:0]       unlock_cnt;
    logic             rst_en;
    logic [3:0]       period;
    logic [3:0]       flags;
    logic [CNT_W-1:0] count;
    logic             pulse;
    logic             irq_req;
  } wwrf_state_t;

  wwrf_state_t s;
  wwrf_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and oscillator tick

  logic [2:0] pins_s;
  logic       tick;

  wwrf_sync #(
    .W   (3),
    .RST (3'h3)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       ({brownout_detect, reset_pin_n, always_on_fuse}),
    .q       (pins_s)
  );

  wwrf_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .tick    (tick)
  );

  logic bor_s;
  logic pin_n_s;
  logic fuse_prog;
  assign bor_s     = pins_s[2];
  assign pin_n_s   = pins_s[1];
  assign fuse_prog = ~pins_s[0];

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode and time-out

  logic             rst_en_eff;
  logic             irq_en_eff;
  logic             running;
  logic [3:0]       code_sat;
  logic [CNT_W-1:0] period_cyc;
  logic             timeout;
  logic             tmo_reset;
  logic             tmo_irq;
  logic             sys_rst;
  logic [7:0]       ctl_read;
  logic [7:0]       sts_read;
  logic             addr_ok;
  logic             ctl_hit;
  logic             sts_hit;

  assign rst_en_eff = s.rst_en | s.flags[STS_WDOG] | fuse_prog;
  assign irq_en_eff = s.irq_en & ~fuse_prog;
  assign running    = rst_en_eff | irq_en_eff;
  assign code_sat   = (s.period > PERIOD_MAX) ? PERIOD_MAX : s.period;
  assign period_cyc = CNT_W'(TIMEOUT_CYCLES) << code_sat;
  assign timeout    = running & tick & (s.count >= period_cyc - 1'b1);
  // combined mode resets only when the earlier interrupt is still pending
  assign tmo_reset  = timeout & rst_en_eff & (~irq_en_eff | s.irq_flag);
  assign tmo_irq    = timeout & irq_en_eff & ~tmo_reset;
  assign sys_rst    = s.pulse | bor_s | ~pin_n_s;

  assign ctl_read = {s.irq_flag, irq_en_eff, s.period[3], s.unlock,
                     rst_en_eff, s.period[2:0]};
  assign sts_read = {4'h0, s.flags};

  assign addr_ok = hsel & htrans[1] & hready;
  assign ctl_hit = haddr[31:2] == WWRF_CTL_ADDR[31:2];
  assign sts_hit = haddr[31:2] == WWRF_STS_ADDR[31:2];

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.wr_ctl = addr_ok & hwrite & ctl_hit;
      next_s.wr_sts = addr_ok & hwrite & sts_hit;
      if (addr_ok & ~hwrite) begin
        next_s.rdata = ctl_hit ? {24'h0, ctl_read} : sts_hit ? {24'h0, sts_read} : 32'h0;
      end
      if (s.unlock) begin
        next_s.unlock_cnt = s.unlock_cnt - 3'h1;
        if (s.unlock_cnt == 3'h1) begin
          next_s.unlock = 1'b0;
        end
      end
      if (s.wr_ctl) begin
        if (hwdata[CTL_IRQ_FLAG]) begin
          next_s.irq_flag = 1'b0;
        end
        next_s.irq_en = hwdata[CTL_IRQ_EN];
        if (hwdata[CTL_RST_EN]) begin
          next_s.rst_en = 1'b1;
        end else if (s.unlock && !s.flags[STS_WDOG]) begin
          next_s.rst_en = 1'b0;
        end
        if (s.unlock) begin
          next_s.period = {hwdata[CTL_PER_HI], hwdata[CTL_PER_LO +: 3]};
        end
        next_s.unlock     = hwdata[CTL_UNLOCK] & hwdata[CTL_RST_EN];
        next_s.unlock_cnt = next_s.unlock ? UNLOCK_CYCLES : 3'h0;
      end
      if (s.wr_sts) begin
        next_s.flags = s.flags & hwdata[3:0];
      end
      if (irq_vector_taken) begin
        next_s.irq_flag = 1'b0;
        if (rst_en_eff) begin
          next_s.irq_en = 1'b0;
        end
      end
      if (wdog_restart || !running) begin
        next_s.count = '0;
      end else if (tick) begin
        next_s.count = timeout ? '0 : s.count + 1'b1;
      end
      if (sys_rst) begin
        // control returns to defaults; after a watchdog reset rst_en stays effective via the flag
        next_s.irq_flag   = 1'b0;
        next_s.irq_en     = 1'b0;
        next_s.unlock     = 1'b0;
        next_s.unlock_cnt = 3'h0;
        next_s.rst_en     = 1'b0;
        next_s.period     = PERIOD_RESET;
        next_s.count      = '0;
      end
      if (tmo_irq) begin
        next_s.irq_flag = 1'b1;
      end
      next_s.pulse = tmo_reset;
      if (tmo_reset) begin
        next_s.flags[STS_WDOG] = 1'b1;
      end
      if (bor_s) begin
        next_s.flags[STS_BOR] = 1'b1;
      end
      if (!pin_n_s) begin
        next_s.flags[STS_PIN] = 1'b1;
      end
      next_s.irq_req = s.irq_flag & irq_en_eff & global_irq_enable;
    end
  end

  // hresetn is the power-on reset: it clears all flags but power-on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{flags: STS_RESET, period: PERIOD_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  logic ready_q;
  logic resp_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end else begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end
  end

  assign hrdata          = s.rdata;
  assign hreadyout       = ready_q;
  assign hresp           = resp_q;
  assign irq_request     = s.irq_req;
  assign sys_reset_pulse = s.pulse;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  pulse_one_cycle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && sys_reset_pulse) |=> !sys_reset_pulse)
    else $error("reset pulse longer than one cycle");

  pulse_sets_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(sys_reset_pulse) |-> s.flags[STS_WDOG])
    else $error("watchdog reset without watchdog flag");

  status_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && addr_ok && !hwrite && sts_hit) |=> hrdata[31:4] == 28'h0)
    else $error("status reserved bits not zero");

  unlock_expires_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(s.unlock) ##0 ce [*4] |=> !s.unlock)
    else $error("change unlock not cleared after four cycles");

  fuse_locks_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fuse_prog |-> ctl_read[CTL_RST_EN] && !ctl_read[CTL_IRQ_EN])
    else $error("fuse does not lock enables");

  irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq_request) |-> $past(global_irq_enable) && $past(s.irq_flag))
    else $error("irq requested without enables");

  flag_holds_en_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s.flags[STS_WDOG] |-> ctl_read[CTL_RST_EN])
    else $error("reset enable clear while watchdog flag set");

  second_timeout_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && timeout && irq_en_eff && rst_en_eff && s.irq_flag) |=> sys_reset_pulse)
    else $error("pending irq time-out gave no reset");

  period_locked_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!s.unlock && !sys_rst) |=> $stable(s.period))
    else $error("period changed while locked");

  vector_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && irq_vector_taken && !tmo_irq) |=> !s.irq_flag)
    else $error("vector did not clear irq flag");

  wdog_flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.flags[STS_WDOG] && !s.wr_sts) |=> s.flags[STS_WDOG])
    else $error("watchdog flag lost without a write");

  poweron_flag_kept_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !s.wr_sts |=> $stable(s.flags[STS_POR]))
    else $error("power-on flag changed without a write");

  first_timeout_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && timeout && irq_en_eff && !s.irq_flag) |=> s.irq_flag && !sys_reset_pulse)
    else $error("first time-out did not raise the irq flag");

  irq_mode_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && timeout && !rst_en_eff) |=> !sys_reset_pulse)
    else $error("time-out reset while reset is disabled");

  fuse_forces_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && timeout && fuse_prog) |=> sys_reset_pulse)
    else $error("programmed fuse time-out gave no reset");

  stopped_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !running) |=> s.count == '0)
    else $error("counter ran while stopped");

  restart_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && wdog_restart) |=> s.count == '0)
    else $error("restart did not clear the counter");
endmodule

// [tb/tb_top.sv]
// self-checking bench of the watchdog with reset-cause flags
module tb_top
  import wwrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] C = WWRF_CTL_ADDR;
  localparam logic [31:0] S = WWRF_STS_ADDR;
  logic        hclk              = 1'b0;
  logic        hresetn           = 1'b0;
  logic        hsel              = 1'b0;
  logic [31:0] haddr             = 32'h0;
  logic [1:0]  htrans            = 2'h0;
  logic        hwrite            = 1'b0;
  logic [31:0] hwdata            = 32'h0;
  logic        wdog_restart      = 1'b1;
  logic        global_irq_enable = 1'b0;
  logic        brownout_detect   = 1'b0;
  logic        reset_pin_n       = 1'b1;
  logic        always_on_fuse    = 1'b1;
  logic        ce                = 1'b1;
  logic        rd_dv             = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq_vector_taken;
  logic        irq_request;
  logic        sys_reset_pulse;
  logic [31:0] q[$];
  int          err_total         = 0;
  int          n_compared        = 0;

  always #5 hclk = ~hclk;

  wwrf_top #(.TIMEOUT_CYCLES(4), .TICK_DIV(2)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .wdog_restart(wdog_restart), .irq_vector_taken(irq_vector_taken),
    .global_irq_enable(global_irq_enable), .brownout_detect(brownout_detect),
    .reset_pin_n(reset_pin_n), .always_on_fuse(always_on_fuse),
    .irq_request(irq_request), .sys_reset_pulse(sys_reset_pulse));

  wwrf_core_model core (.hclk(hclk), .hresetn(hresetn), .irq_request(irq_request),
    .irq_vector_taken(irq_vector_taken));

  ////////////////////////////////////////////////////////////////
  task conclude();
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task wrdy();
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) begin
      chk(1'b0, "bus stall");
      conclude();
    end
  endtask

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dv <= ~w;
    wrdy();
    rd_dv <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask

  task rd(input logic [31:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    xfer(1'b0, a, 32'h0);
  endtask

  // timed sequence: unlock with reset-enable, then the new value
  task unlk(input logic [7:0] d);
    wr(C, 8'h18);
    wr(C, d);
  endtask

  // cycles until irq_request (s=0) or sys_reset_pulse (s=1)
  task wt(input bit s, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge hclk);
      if ((s ? sys_reset_pulse : irq_request) === 1'b1) break;
    end
    if (n == lim) begin
      chk(1'b0, "event missing");
      conclude();
    end
  endtask

  always @(posedge hclk) begin
    logic [31:0] e;
    if (rd_dv === 1'b1 && hreadyout === 1'b1) begin
      e = q.pop_front();
      chk(hrdata === e && hresp === 1'b0, "read data");
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int m;
    int k;
    logic [31:0] r;
    logic [3:0] c;
    void'($urandom(45));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(S, 8'h01);
    rd(C, 8'h00);
    rd(32'h0000_0008, 8'h00);
    wr(S, 8'h00);
    rd(S, 8'h00);
    reset_pin_n <= 1'b0;
    repeat (5) @(posedge hclk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(S, 8'h02);
    brownout_detect <= 1'b1;
    repeat (5) @(posedge hclk);
    brownout_detect <= 1'b0;
    repeat (4) @(posedge hclk);
    rd(S, 8'h06);
    r = $urandom;
    wr(S, r[7:0]);
    rd(S, {4'h0, r[3:0] & 4'h6});
    wr(S, 8'h00);
    wr(C, 8'h40);
    wdog_restart <= 1'b0;
    repeat (20) @(posedge hclk);
    chk(irq_request === 1'b0, "masked irq");
    wdog_restart <= 1'b1;
    rd(C, 8'hc0);
    wr(C, 8'hc0);
    rd(C, 8'h40);
    global_irq_enable <= 1'b1;
    wdog_restart <= 1'b0;
    wt(1'b0, 40, n);
    wdog_restart <= 1'b1;
    repeat (6) @(posedge hclk);
    rd(C, 8'h40);
    for (k = 0; k < 3; k++) begin
      c = (k == 2) ? 4'ha : k[3:0];
      unlk({2'b01, c[3], 2'b00, c[2:0]});
      wdog_restart <= 1'b0;
      wt(1'b0, 5000, n);
      wdog_restart <= 1'b1;
      m = 8 << ((k == 2) ? 9 : k);
      chk(n + 4 >= m && n <= m + 4, "time-out period");
      repeat (6) @(posedge hclk);
    end
    unlk(8'h40);
    ce <= 1'b0;
    wdog_restart <= 1'b0;
    repeat (30) @(posedge hclk);
    chk(irq_request === 1'b0, "clock enable low did not freeze");
    ce <= 1'b1;
    wt(1'b0, 40, n);
    wdog_restart <= 1'b1;
    chk(n >= 4 && n <= 12, "period after clock enable");
    repeat (6) @(posedge hclk);
    unlk(8'h08);
    wdog_restart <= 1'b0;
    wt(1'b1, 40, n);
    @(posedge hclk);
    chk(sys_reset_pulse === 1'b0, "pulse width");
    wt(1'b1, 40, n);
    chk(n >= 3 && n <= 12, "repeat reset");
    wdog_restart <= 1'b1;
    rd(S, 8'h08);
    rd(C, 8'h08);
    unlk(8'h00);
    rd(C, 8'h08);
    wr(S, 8'h00);
    rd(C, 8'h08);
    wr(C, 8'h08);
    wr(C, 8'h00);
    rd(C, 8'h08);
    wr(C, 8'h18);
    rd(C, 8'h18);
    repeat (6) @(posedge hclk);
    rd(C, 8'h08);
    unlk(8'h00);
    rd(C, 8'h00);
    global_irq_enable <= 1'b0;
    wr(C, 8'h48);
    wdog_restart <= 1'b0;
    wt(1'b1, 60, n);
    wdog_restart <= 1'b1;
    chk(n >= 12 && n <= 20, "second time-out");
    wr(S, 8'h00);
    global_irq_enable <= 1'b1;
    wr(C, 8'h48);
    wdog_restart <= 1'b0;
    wt(1'b0, 40, n);
    wdog_restart <= 1'b1;
    repeat (6) @(posedge hclk);
    rd(C, 8'h08);
    wr(C, 8'h48);
    rd(C, 8'h48);
    unlk(8'h00);
    always_on_fuse <= 1'b0;
    repeat (4) @(posedge hclk);
    wr(C, 8'h40);
    rd(C, 8'h08);
    wdog_restart <= 1'b0;
    wt(1'b1, 40, n);
    wdog_restart <= 1'b1;
    always_on_fuse <= 1'b1;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(S, 8'h01);
    rd(C, 8'h00);
    conclude();
  end
endmodule

// [tb/wwrf_core_model.sv]
// core model that executes the watchdog interrupt vector
module wwrf_core_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic irq_request,
  output logic      irq_vector_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  initial irq_vector_taken = 1'b0;
  // vector after zero to two cycles, then a gap while the request drops
  always begin
    @(posedge hclk);
    if (hresetn === 1'b1 && irq_request === 1'b1) begin
      repeat ($urandom_range(2, 0)) @(posedge hclk);
      irq_vector_taken <= 1'b1;
      @(posedge hclk);
      irq_vector_taken <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  end
endmodule
